// file: stu_defines.svh
// Purpose: constants for the serial terminal controller
// Assumes: 10 MHz reference clock
// Notes:   offsets, framing and timing counts
`ifndef STU_DEFINES_SVH
`define STU_DEFINES_SVH
// ********************
// framing
// ********************
`define STU_DATA_BITS      4'h8
`define STU_CHAR_UNITS     4'hB
`define STU_STOP_BITS      4'h2
// ********************
// timing
// ********************
`define STU_CLK_HZ         10000000
`define STU_BAUD           110
`define STU_BIT_CYCLES     (`STU_CLK_HZ / `STU_BAUD)
`define STU_HALF_CYCLES    (`STU_BIT_CYCLES / 2)
// ********************
// device addresses and fifo depth
// ********************
`define STU_ADDR_BASE      8'h02
`define STU_FIFO_DEPTH     8
`endif

// file: stu_fifo.sv
// Purpose: small flip-flop FIFO with valid/ready on both sides
// Assumes: single clock
// Notes:   full and empty are exact
`timescale 1ns/1ps
`default_nettype none
module stu_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  // clock and reset
  input  wire logic             ref_clk,
  input  wire logic             reset_n,
  // fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  // ********************
  // state
  // ********************
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               wr_ptr;
    logic [AW-1:0]               rd_ptr;
    logic [AW:0]                 count;
  } stu_fifo_st_t;
  stu_fifo_st_t st_reg;
  stu_fifo_st_t st_next;
  logic push;
  logic pop;
  assign in_ready  = (st_reg.count != DEPTH[AW:0]);
  assign out_valid = (st_reg.count != '0);
  assign out_data  = st_reg.mem[st_reg.rd_ptr];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  // pointer and storage update
  always_comb begin
    st_next = st_reg;
    if (push) begin
      st_next.mem[st_reg.wr_ptr] = in_data;
      st_next.wr_ptr = (st_reg.wr_ptr == AW'(DEPTH - 1)) ? '0 : st_reg.wr_ptr + 1'b1;
    end
    if (pop) begin
      st_next.rd_ptr = (st_reg.rd_ptr == AW'(DEPTH - 1)) ? '0 : st_reg.rd_ptr + 1'b1;
    end
    if (push && !pop) begin
      st_next.count = st_reg.count + 1'b1;
    end else if (pop && !push) begin
      st_next.count = st_reg.count - 1'b1;
    end
  end
  // register the state
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end
endmodule : stu_fifo
`default_nettype wire

// file: stu_monitor.sv
// Purpose: port assertions for the terminal controller
// Assumes: 10 MHz ref_clk
// Notes:   bound from the bench top
`timescale 1ns/1ps
`default_nettype none
module stu_monitor #(
  parameter int BIT = 90909  // cycles per bit
) (
  // clock and reset
  input wire logic       ref_clk,
  input wire logic       reset_n,
  // computer side
  input wire logic [1:0] unit_sel,
  input wire logic [7:0] dev_addr,
  input wire logic       out_strobe,
  input wire logic       out_ready,
  input wire logic       in_strobe,
  input wire logic [7:0] in_data,
  input wire logic       in_full,
  input wire logic       reader_on_set,
  input wire logic       reader_off_set,
  // terminal side
  input wire logic       tx_line,
  input wire logic       reader_relay
);
  logic [31:0] run_reg;        // samples at current tx level
  logic        line_reg;       // previous tx sample
  logic [7:0]  tx_addr;        // transmit address of this unit
  assign tx_addr = {5'h00, unit_sel, 1'b0} + 8'h02;
  // run length of tx_line; idle counts as long after reset
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      run_reg  <= 32'h7fff_ffff;
      line_reg <= 1'b1;
    end else begin
      line_reg <= tx_line;
      run_reg  <= (tx_line != line_reg) ? 32'h0000_0001 : run_reg + 32'h0000_0001;
    end
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  // write taken while the line has idled longer than ten bit times
  sequence tx_take;
    out_strobe && out_ready && dev_addr == tx_addr && tx_line && run_reg > 10 * BIT;
  endsequence
  sequence start_bit;
    ##[3:4] !tx_line;
  endsequence
  reset_vals_a: assert property ($rose(reset_n) |-> tx_line && out_ready && !in_full)
    else $error("outputs not at reset values");
  tx_start_a: assert property (tx_take |-> start_bit)
    else $error("start bit late");
  tx_bit_edge_a: assert property ($rose(tx_line) |-> run_reg % BIT == 0)
    else $error("bit time wrong");
  tx_low_len_a: assert property (!tx_line && !line_reg |-> run_reg < 9 * BIT)
    else $error("stop bits missing");
  rx_load_a: assert property ($changed(in_data) |-> in_full)
    else $error("byte without flag");
  rx_hold_a: assert property (in_full && !(in_strobe && dev_addr == tx_addr + 8'h01)
    |=> in_full) else $error("flag lost");
  rx_clear_a: assert property ($fell(in_full) |-> $past(in_strobe)
    && $past(dev_addr) == tx_addr + 8'h01) else $error("flag cleared wrongly");
  relay_on_a: assert property (reader_on_set |=> reader_relay)
    else $error("relay not on");
  relay_off_a: assert property (reader_off_set && !reader_on_set |=> !reader_relay)
    else $error("relay not off");
endmodule : stu_monitor
`default_nettype wire

// file: stu_pkg.sv
// Purpose: types for the serial terminal controller
// Assumes: nothing
// Notes:   state codes are one-hot
package stu_pkg;
  // transmitter states
  typedef enum logic [2:0] {
    STU_TX_IDLE = 3'b001,
    STU_TX_SHIFT = 3'b010,
    STU_TX_LOAD = 3'b100
  } stu_tx_state_t;
  // receiver states
  typedef enum logic [2:0] {
    STU_RX_IDLE = 3'b001,
    STU_RX_DATA = 3'b010,
    STU_RX_STOP = 3'b100
  } stu_rx_state_t;
endpackage : stu_pkg

// file: stu_term_model.sv
// Purpose: terminal keyboard and printer model
// Assumes: bit time set by parameter BIT
// Notes:   line idles at mark
`timescale 1ns/1ps
`default_nettype none
module stu_term_model #(
  parameter int BIT = 90909  // cycles per bit
) (
  // clock
  input  wire logic       ref_clk,
  // serial lines
  input  wire logic       tx_line,
  output logic            rx_line,
  // bytes heard by the printer
  output logic            got_valid,
  output logic [7:0]      got_data
);
  logic glitch;  // line rose during the start half
  initial begin
    rx_line   = 1'b1;
    got_valid = 1'b0;
    got_data  = 8'h00;
  end
  // keyboard: start, data lsb first, two stop, back to mark
  task automatic send(input logic [7:0] b);
    logic [10:0] f;
    f = {2'b11, b, 1'b0};
    for (int i = 0; i < 11; i++) begin
      rx_line <= f[i];
      repeat (BIT) @(posedge ref_clk);
    end
  endtask : send
  // printer: mid-bit sampling, drops false starts and bad stop bits
  // a start that rises before its middle (a cut frame) re-arms at once
  always begin
    @(negedge tx_line);
    glitch = 1'b0;
    for (int i = 0; i < BIT / 2 && !glitch; i++) begin
      @(posedge ref_clk);
      glitch = tx_line;
    end
    if (!glitch) begin
      for (int i = 0; i < 8; i++) begin
        repeat (BIT) @(posedge ref_clk);
        got_data[i] <= tx_line;
      end
      repeat (BIT) @(posedge ref_clk);
      got_valid <= tx_line;
      @(posedge ref_clk);
      got_valid <= 1'b0;
    end
  end
endmodule : stu_term_model
`default_nettype wire

// file: stu_uart.sv
// Purpose: full-duplex 110 baud terminal controller
// Assumes: 10 MHz ref_clk, asynchronous active-low reset
// Notes:   transmit bytes queue in an 8-word FIFO
//          the bit time is a parameter whose default is the 110 baud count;
//          a bench may shorten it to keep frames short
//          receive and transmit share only the clock, reset and the base_addr decode of dev_addr
// What this block does
// - 11-unit frame: start, eight data, two stop
// - received byte presented as one parallel word
// - sends computer byte serially at 110 baud
// - separate receive and transmit paths run concurrently
// - answers transmit and receive device addresses
// - computer-set output drives tape reader relay
`timescale 1ns/1ps
`default_nettype none
`include "stu_defines.svh"
module stu_uart #(
  // reference clock cycles per bit time
  parameter int BIT_CYCLES = `STU_BIT_CYCLES
) (
  // clock and reset
  input  wire logic       ref_clk,
  input  wire logic       reset_n,
  // instance strap: 0, 1 or 2 selects the address pair
  input  wire logic [1:0] unit_sel,
  // computer i/o bus
  input  wire logic [7:0] dev_addr,
  input  wire logic       out_strobe,
  input  wire logic [7:0] out_data,
  output logic            out_ready,
  input  wire logic       in_strobe,
  output logic [7:0]      in_data,
  output logic            in_full,
  input  wire logic       reader_on_set,
  input  wire logic       reader_off_set,
  // terminal side
  input  wire logic       rx_line,
  output logic            tx_line,
  output logic            reader_relay
);
  import stu_pkg::*;
  // 90909 cycles per bit at the default needs seventeen bits
  localparam logic [16:0] BIT_CNT  = 17'(BIT_CYCLES);
  localparam logic [16:0] HALF_CNT = 17'(BIT_CYCLES / 2);
  // ********************
  // state
  // ********************
  typedef struct packed {
    stu_tx_state_t tx_state;
    logic [16:0]   tx_timer;  // counts down one bit time
    logic [3:0]    tx_units;
    logic [10:0]   tx_shift;
    logic          tx_out;
    stu_rx_state_t rx_state;
    logic [2:0]    rx_sync;
    logic          rx_filt;   // receive level after the agreement filter
    logic [16:0]   rx_timer;  // counts to mid-bit, then one bit time
    logic [3:0]    rx_bits;
    logic [7:0]    rx_shift;
    logic [7:0]    rx_buf;
    logic          rx_full;
    logic          relay;
  } stu_st_t;
  stu_st_t st_reg;
  stu_st_t st_next;
  // fifo wires
  logic       tx_wr_addr;   // transmit address decoded
  logic       rx_rd_addr;   // receive address decoded
  logic       fifo_valid;
  logic       fifo_pop;
  logic [7:0] fifo_data;
  logic [7:0] base_addr;
  logic       rx_level;     // filtered receive line
  // address pair for this instance
  assign base_addr  = `STU_ADDR_BASE + {5'h00, unit_sel, 1'b0};
  assign tx_wr_addr = (dev_addr == base_addr);
  assign rx_rd_addr = (dev_addr == (base_addr + 8'h01));
  assign fifo_pop   = (st_reg.tx_state == STU_TX_IDLE);
  // transmit buffer, independent of the receiver
  stu_fifo #(
    .WIDTH (8),
    .DEPTH (`STU_FIFO_DEPTH)
  ) u_tx_fifo (
    .ref_clk   (ref_clk),
    .reset_n   (reset_n),
    .in_valid  (out_strobe && tx_wr_addr),
    .in_ready  (out_ready),
    .in_data   (out_data),
    .out_valid (fifo_valid),
    .out_ready (fifo_pop),
    .out_data  (fifo_data)
  );
  // ********************
  // receive line filter
  // ********************
  // the level seen by the receiver changes only when the second and third
  // stages agree, so a one-cycle glitch on the pin never starts a character;
  // the extra register costs one cycle of latency, far below a bit time
  assign rx_level = st_reg.rx_filt;
  // outputs come from flip-flops
  assign tx_line      = st_reg.tx_out;
  assign in_data      = st_reg.rx_buf;
  assign in_full      = st_reg.rx_full;
  assign reader_relay = st_reg.relay;
  // ********************
  // next-state logic
  // ********************
  always_comb begin
    st_next = st_reg;
    st_next.rx_sync = {st_reg.rx_sync[1:0], rx_line};
    // filtered level follows the pin once the late stages agree
    if (st_reg.rx_sync[1] == st_reg.rx_sync[2]) begin
      st_next.rx_filt = st_reg.rx_sync[2];
    end
    // relay switched by the computer
    if (reader_on_set) begin
      st_next.relay = 1'b1;
    end else if (reader_off_set) begin
      st_next.relay = 1'b0;
    end
    // transmitter
    unique case (st_reg.tx_state)
      STU_TX_IDLE: begin
        st_next.tx_out = 1'b1;
        if (fifo_valid) begin
          // stop, stop, data lsb first, start
          st_next.tx_shift = {2'b11, fifo_data, 1'b0};
          st_next.tx_state = STU_TX_LOAD;
        end
      end
      STU_TX_LOAD: begin
        // start bit goes out now; ten more units follow
        st_next.tx_out   = st_reg.tx_shift[0];
        st_next.tx_shift = {1'b1, st_reg.tx_shift[10:1]};
        st_next.tx_timer = BIT_CNT - 17'h0_0001;
        st_next.tx_units = `STU_CHAR_UNITS - 4'h1;
        st_next.tx_state = STU_TX_SHIFT;
      end
      STU_TX_SHIFT: begin
        // hold the current unit for a full bit time
        if (st_reg.tx_timer != 17'h0_0000) begin
          st_next.tx_timer = st_reg.tx_timer - 17'h0_0001;
        end else if (st_reg.tx_units != 4'h0) begin
          // next unit of the character
          st_next.tx_out   = st_reg.tx_shift[0];
          st_next.tx_shift = {1'b1, st_reg.tx_shift[10:1]};
          st_next.tx_units = st_reg.tx_units - 4'h1;
          st_next.tx_timer = BIT_CNT - 17'h0_0001;
        end else begin
          // second stop bit done: line rests at mark
          st_next.tx_state = STU_TX_IDLE;
        end
      end
      default: st_next.tx_state = STU_TX_IDLE;
    endcase
    // receive buffer read by the computer
    // a read and a new byte in one cycle: the set below wins
    if (in_strobe && rx_rd_addr) begin
      st_next.rx_full = 1'b0;
    end
    // receiver
    unique case (st_reg.rx_state)
      STU_RX_IDLE: begin
        if (!rx_level) begin
          // start edge: wait half a bit to its middle
          st_next.rx_timer = HALF_CNT;
          st_next.rx_bits  = 4'h0;
          st_next.rx_state = STU_RX_DATA;
        end
      end
      STU_RX_DATA: begin
        // count down to the middle of the current bit
        if (st_reg.rx_timer != 17'h0_0000) begin
          st_next.rx_timer = st_reg.rx_timer - 17'h0_0001;
        end else if (st_reg.rx_bits == 4'h0 && rx_level) begin
          st_next.rx_state = STU_RX_IDLE;                         // false start
        end else begin
          // the start bit itself is not shifted in
          st_next.rx_timer = BIT_CNT - 17'h0_0001;
          if (st_reg.rx_bits != 4'h0) begin
            st_next.rx_shift = {rx_level, st_reg.rx_shift[7:1]};
          end
          if (st_reg.rx_bits == `STU_DATA_BITS) begin
            st_next.rx_state = STU_RX_STOP;
          end else begin
            st_next.rx_bits = st_reg.rx_bits + 4'h1;
          end
        end
      end
      STU_RX_STOP: begin
        // a space at the middle of the first stop bit drops the byte
        if (st_reg.rx_timer != 17'h0_0000) begin
          st_next.rx_timer = st_reg.rx_timer - 17'h0_0001;
        end else begin
          // middle of first stop bit: hand over the byte
          if (rx_level) begin
            st_next.rx_buf  = st_reg.rx_shift;
            st_next.rx_full = 1'b1;
          end
          st_next.rx_state = STU_RX_IDLE;
        end
      end
      default: st_next.rx_state = STU_RX_IDLE;
    endcase
  end
  // register the state
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      st_reg          <= '0;
      st_reg.tx_state <= STU_TX_IDLE;
      st_reg.rx_state <= STU_RX_IDLE;
      st_reg.tx_out   <= 1'b1;
      st_reg.rx_sync  <= 3'b111;
      st_reg.rx_filt  <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end
endmodule : stu_uart
`default_nettype wire

// file: tb_stu_uart.sv
// Purpose: self-checking bench for the terminal controller
// Assumes: bit time shortened to 64 cycles, under two thousand cycles in all
// Notes:   expected bytes are queued as they are sent
`timescale 1ns/1ps
`default_nettype none
module tb_stu_uart;
  logic        ref_clk = 1'b0;
  logic        reset_n = 1'b0;
  logic [1:0]  unit_sel = 2'h0;
  logic [7:0]  dev_addr = 8'h00;
  logic        out_strobe = 1'b0;
  logic [7:0]  out_data = 8'h00;
  logic        in_strobe = 1'b0;
  logic        reader_on_set = 1'b0;
  logic        reader_off_set = 1'b0;
  logic        rx_line, tx_line, out_ready, in_full, reader_relay, got_valid;
  logic        full_reg = 1'b0;
  logic [7:0]  in_data, got_data, b;
  logic [31:0] lfsr = 32'h0000_54b9;
  logic [7:0]  tx_q[$], rx_q[$];
  logic [2:0]  pat[4] = '{3'b101, 3'b010, 3'b111, 3'b010};  // on, off, relay after
  int          n_mismatch = 0, samples_checked = 0, cycles = 0;
  localparam int BIT = 64;  // shortened bit time keeps the run short
  always #50 ref_clk = ~ref_clk;
  stu_uart #(.BIT_CYCLES(BIT)) u_stu_uart (.*);
  stu_term_model #(.BIT(BIT)) u_stu_term_model (.*);
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr_next
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic conclude();
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : conclude
  // back-to-back one-cycle writes of random bytes
  task automatic burst(input logic [7:0] a, input int n, input logic note);
    for (int i = 0; i < n; i++) begin
      @(posedge ref_clk);
      lfsr = lfsr_next(lfsr);
      dev_addr   <= a;
      out_data   <= lfsr[7:0];
      out_strobe <= 1'b1;
      if (note) tx_q.push_back(lfsr[7:0]);
    end
    @(posedge ref_clk);
    out_strobe <= 1'b0;
    @(negedge ref_clk);
  endtask : burst
  // one-cycle pulse on relay and read strobes
  task automatic pulse(input logic on, input logic off, input logic rd, input logic [7:0] a);
    @(posedge ref_clk);
    reader_on_set  <= on;
    reader_off_set <= off;
    in_strobe      <= rd;
    dev_addr       <= a;
    @(posedge ref_clk);
    reader_on_set  <= 1'b0;
    reader_off_set <= 1'b0;
    in_strobe      <= 1'b0;
    @(negedge ref_clk);
  endtask : pulse
  // watcher: retire the oldest note on each result
  always @(posedge ref_clk) begin
    if (got_valid) check(got_data, tx_q.pop_front());
    if (in_full && !full_reg) check(in_data, rx_q.pop_front());
    full_reg <= in_full;
    cycles++;
    if (cycles > 5000) begin
      n_mismatch++;
      conclude();
    end
  end
  initial begin
    repeat (2) @(posedge ref_clk);
    reset_n <= 1'b1;
    @(negedge ref_clk);
    check({4'h0, tx_line, out_ready, in_full, reader_relay}, 8'h0c);
    for (int i = 0; i < 4; i++) begin
      pulse(pat[i][2], pat[i][1], 1'b0, 8'h00);
      check({7'h00, reader_relay}, {7'h00, pat[i][0]});
    end
    $display("test reset and relay done");
    for (int u = 0; u < 3; u++) begin
      @(posedge ref_clk);
      unit_sel <= u[1:0];
      burst(8'(2 * u + 3), 10, 1'b0);
      check({7'h00, out_ready}, 8'h01);
      burst(8'(2 * u + 2), 10, 1'b0);
      check({7'h00, out_ready}, 8'h00);
      @(posedge ref_clk);
      reset_n <= 1'b0;
      repeat (2) @(posedge ref_clk);
      reset_n <= 1'b1;
      @(negedge ref_clk);
    end
    $display("test address and fill done");
    lfsr = lfsr_next(lfsr);
    b = lfsr[7:0];
    rx_q.push_back(b);
    fork
      u_stu_term_model.send(b);
      burst(8'h06, 2, 1'b1);
    join
    while (tx_q.size() > 0 || rx_q.size() > 0) @(posedge ref_clk);
    $display("test duplex done");
    pulse(1'b0, 1'b0, 1'b1, 8'h06);
    check({7'h00, in_full}, 8'h01);
    pulse(1'b0, 1'b0, 1'b1, 8'h07);
    check({7'h00, in_full}, 8'h00);
    $display("test clear done");
    conclude();
  end
endmodule : tb_stu_uart
bind stu_uart stu_monitor #(.BIT(BIT_CYCLES)) u_stu_monitor (.*);
`default_nettype wire
